// ---- core/pmsfr_pkg.sv ----
// power management sfr bank: offsets, field positions, reset values
// assumes an 8-bit sfr bus with 8-bit addresses from the core
package pmsfr_pkg;
  localparam logic [7:0] PMSFR_ADDR_KEY = 8'hC1;
  localparam logic [7:0] PMSFR_ADDR_ADC_START = 8'hD8;
  localparam logic [7:0] PMSFR_ADDR_EVT_EN = 8'hEC;
  localparam logic [7:0] PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS = 8'hF4;
  localparam logic [7:0] PMSFR_ADDR_POLICY = 8'hF5;
  localparam logic [7:0] PMSFR_ADDR_EVT_FLAGS = 8'hF8;
  localparam logic [7:0] PMSFR_ADDR_SCRATCH_A = 8'hFB;
  localparam logic [7:0] PMSFR_ADDR_SCRATCH_B = 8'hFC;
  localparam logic [7:0] PMSFR_ADDR_PIN_CFG = 8'hFF;
  localparam logic [7:0] PMSFR_KEY_UNLOCK = 8'hEA;
  // event flag / enable bit positions
  localparam int PMSFR_BIT_RESTORED = 7;
  localparam int PMSFR_BIT_SUMMARY = 6;
  localparam int PMSFR_BIT_SAG = 5;
  localparam int PMSFR_BIT_BATSW = 1;
  localparam int PMSFR_BIT_SUPLOW = 0;
  // peripheral config bit positions
  localparam int PMSFR_BIT_RXWAKE = 7;
  localparam int PMSFR_BIT_SRC = 6;
  localparam int PMSFR_BIT_MAIN_OK = 5;
  localparam int PMSFR_BIT_PLL_LOCK_FAULT = 4;
  // acknowledge bit of the adc start register
  localparam int PMSFR_BIT_PLL_ACK = 0;
  localparam logic [7:0] PMSFR_EVT_MASK = 8'hA3;
  localparam logic [7:0] PMSFR_RST_ZERO = 8'h00;
  localparam logic [1:0] PMSFR_RST_POLICY = 2'h0;
  localparam logic [1:0] PMSFR_RST_RXFN = 2'h0;
  localparam logic PMSFR_RST_SRC = 1'b1;
  localparam logic PMSFR_RST_MAIN_OK = 1'b1;
  // pin input synchroniser depth
  localparam int PMSFR_SYNC_STAGES = 3;
  typedef enum logic [1:0] {PMSFR_POL_MAIN_LOW, PMSFR_POL_MAIN_OR_SUP, PMSFR_POL_OFF} pmsfr_policy_t;
endpackage : pmsfr_pkg

// ---- core/pmsfr_evt_if.sv ----
// carrier between the bank and its event-capture submodule
// assumes one clock domain, mclk
`timescale 1ns/1ps
interface pmsfr_evt_if;
  logic [7:0] raw_evt;
  logic [7:0] clr_mask;
  logic [7:0] flags;
  modport bank (output raw_evt, output clr_mask, input flags);
  modport capture (input raw_evt, input clr_mask, output flags);
endinterface : pmsfr_evt_if

// ---- core/pmsfr_sync.sv ----
// three-stage pin synchroniser; a change counts when stages two and three agree
// assumes an asynchronous input and a free-running mclk
`timescale 1ns/1ps
module pmsfr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  import pmsfr_pkg::*;
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] hold_reg;

  // shift chain; first stage is read only by the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // settled value; all stages reset to the idle level so no false edge follows reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_reg <= RESET_VAL;
    end
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          hold_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign stable_out = hold_reg;
endmodule : pmsfr_sync

// ---- core/pmsfr_capture.sv ----
// sticky event flags: set on a raw event, set wins over software clear
// assumes raw events are single-cycle pulses on mclk
`timescale 1ns/1ps
module pmsfr_capture (
  input wire logic mclk,
  input wire logic rst_n,
  pmsfr_evt_if.capture evt
);
  import pmsfr_pkg::*;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;

  // set beats clear so a same-cycle event is never lost
  always_comb
  begin
    flag_next = ((flag_reg & ~evt.clr_mask) | evt.raw_evt) & PMSFR_EVT_MASK;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_reg <= PMSFR_RST_ZERO;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign evt.flags = flag_reg;
endmodule : pmsfr_capture

// ---- core/pmsfr_bank.sv ----
// power management sfr bank: flags, enables, switchover policy,
// peripheral config/status, pin-config key guard and two scratch pads
// assumes a single-cycle sfr bus from the core on mclk; analog status
// arrives asynchronously and passes the three-stage synchroniser
`timescale 1ns/1ps

module pmsfr_bank (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic switched_supply_source_in,
  input wire logic main_supply_ok_in,
  input wire logic voltage_sag_evt,
  input wire logic supervisory_low_in,
  input wire logic pll_unlock_in,
  input wire logic rx_wake_evt,
  output logic [1:0] switchover_policy_sel,
  output logic [1:0] rx_pin_function,
  output logic rx_wake_enable,
  output logic [7:0] pin_function_config,
  output logic power_event_irq
);
  import pmsfr_pkg::*;

  pmsfr_evt_if evt ();

  logic [7:0] unlock_key_reg;
  logic [7:0] power_event_enable_reg;
  logic [1:0] switchover_policy_sel_reg;
  logic [1:0] rx_pin_function_reg;
  logic rx_wake_enable_reg;
  logic [7:0] pin_function_config_reg;
  logic [7:0] retained_scratch_a_reg;
  logic [7:0] retained_scratch_b_reg;
  logic rx_wake_flag_reg;
  logic pll_lock_fault_reg;
  logic [7:0] sfr_rdata_reg;
  logic power_event_irq_reg;
  logic [7:0] raw_evt_next;
  logic [7:0] clr_mask_next;
  logic [7:0] enabled_flags;
  logic pm_summary;
  logic [3:0] pin_sync;
  logic src_prev_reg;
  logic sup_prev_reg;
  logic pll_prev_reg;
  logic sync_valid_reg;

  // one-hot address decode used by the write paths; the read path decodes with a case
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  // analog status crosses in through three synchroniser flops and a hold flop each
  pmsfr_sync #(
    .WIDTH(4),
    .RESET_VAL({1'b0, 1'b0, PMSFR_RST_MAIN_OK, PMSFR_RST_SRC})
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({pll_unlock_in, supervisory_low_in, main_supply_ok_in, switched_supply_source_in}),
    .stable_out(pin_sync)
  );

  pmsfr_capture u_capture (
    .mclk(mclk),
    .rst_n(rst_n),
    .evt(evt)
  );

  // previous settled levels for edge detection
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_prev_reg <= PMSFR_RST_SRC;
      sup_prev_reg <= 1'b0;
      pll_prev_reg <= 1'b0;
      sync_valid_reg <= 1'b0;
    end
    else
    begin
      src_prev_reg <= pin_sync[0];
      sup_prev_reg <= pin_sync[2];
      pll_prev_reg <= pin_sync[3];
      sync_valid_reg <= 1'b1;
    end
  end

  // enabled events; the summary flag is derived, never stored
  always_comb
  begin
    enabled_flags = evt.flags & power_event_enable_reg & PMSFR_EVT_MASK;
    pm_summary = |enabled_flags;
  end

  // raw event pulses into the sticky flags
  always_comb
  begin
    raw_evt_next = PMSFR_RST_ZERO;
    if (sync_valid_reg)
    begin
      raw_evt_next[PMSFR_BIT_RESTORED] = pin_sync[0] & ~src_prev_reg;
      raw_evt_next[PMSFR_BIT_BATSW] = ~pin_sync[0] & src_prev_reg;
      raw_evt_next[PMSFR_BIT_SUPLOW] = pin_sync[2] & ~sup_prev_reg;
    end
    raw_evt_next[PMSFR_BIT_SAG] = voltage_sag_evt;
  end

  // software clears a flag by writing 0 to it
  always_comb
  begin
    clr_mask_next = PMSFR_RST_ZERO;
    if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_EVT_FLAGS))
    begin
      clr_mask_next = ~sfr_wdata & PMSFR_EVT_MASK;
    end
  end

  assign evt.raw_evt = raw_evt_next;
  assign evt.clr_mask = clr_mask_next;

  // key register; the core is expected to zero it after use
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unlock_key_reg <= PMSFR_RST_ZERO;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_KEY))
    begin
      unlock_key_reg <= sfr_wdata;
    end
  end

  // guarded pin config; writes without the key are dropped silently
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_function_config_reg <= PMSFR_RST_ZERO;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_PIN_CFG) && unlock_key_reg == PMSFR_KEY_UNLOCK)
    begin
      pin_function_config_reg <= sfr_wdata;
    end
  end

  // enable register; reserved bits held at zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_event_enable_reg <= PMSFR_RST_ZERO;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_EVT_EN))
    begin
      power_event_enable_reg <= sfr_wdata & PMSFR_EVT_MASK;
    end
  end

  // switchover policy; upper bits are not stored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switchover_policy_sel_reg <= PMSFR_RST_POLICY;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_POLICY))
    begin
      switchover_policy_sel_reg <= sfr_wdata[1:0];
    end
  end

  // receive pin function field
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_pin_function_reg <= PMSFR_RST_RXFN;
      rx_wake_enable_reg <= 1'b0;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS))
    begin
      rx_pin_function_reg <= sfr_wdata[1:0];
      rx_wake_enable_reg <= (sfr_wdata[1:0] == 2'h3);
    end
  end

  // wake flag only when rx wake mode is selected; set wins over clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_wake_flag_reg <= 1'b0;
    end
    else if (rx_wake_evt && rx_pin_function_reg == 2'h3)
    begin
      rx_wake_flag_reg <= 1'b1;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS) && !sfr_wdata[PMSFR_BIT_RXWAKE])
    begin
      rx_wake_flag_reg <= 1'b0;
    end
  end

  // pll fault sticky until acknowledged through the adc start register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_lock_fault_reg <= 1'b0;
    end
    else if (sync_valid_reg && pin_sync[3] && !pll_prev_reg)
    begin
      pll_lock_fault_reg <= 1'b1;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_ADC_START) && sfr_wdata[PMSFR_BIT_PLL_ACK])
    begin
      pll_lock_fault_reg <= 1'b0;
    end
  end

  // scratch pads live on the power-on reset only, so system resets keep them
  always_ff @(posedge mclk or negedge por_n)
  begin
    if (!por_n)
    begin
      retained_scratch_a_reg <= PMSFR_RST_ZERO;
      retained_scratch_b_reg <= PMSFR_RST_ZERO;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_SCRATCH_A))
    begin
      retained_scratch_a_reg <= sfr_wdata;
    end
    else if (sfr_wr && hit(sfr_addr, PMSFR_ADDR_SCRATCH_B))
    begin
      retained_scratch_b_reg <= sfr_wdata;
    end
  end

  // registered read data; unmapped and write-only addresses read zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sfr_rdata_reg <= PMSFR_RST_ZERO;
    end
    else if (sfr_rd)
    begin
      case (sfr_addr)
        PMSFR_ADDR_EVT_FLAGS:
        begin
          sfr_rdata_reg <= evt.flags | {1'b0, pm_summary, 6'h00};
        end
        PMSFR_ADDR_EVT_EN:
        begin
          sfr_rdata_reg <= power_event_enable_reg;
        end
        PMSFR_ADDR_POLICY:
        begin
          sfr_rdata_reg <= {6'h00, switchover_policy_sel_reg};
        end
        PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS:
        begin
          sfr_rdata_reg <= {rx_wake_flag_reg, pin_sync[0], pin_sync[1], pll_lock_fault_reg,
                            2'h0, rx_pin_function_reg};
        end
        PMSFR_ADDR_PIN_CFG:
        begin
          sfr_rdata_reg <= pin_function_config_reg;
        end
        PMSFR_ADDR_KEY:
        begin
          sfr_rdata_reg <= unlock_key_reg;
        end
        PMSFR_ADDR_SCRATCH_A:
        begin
          sfr_rdata_reg <= retained_scratch_a_reg;
        end
        PMSFR_ADDR_SCRATCH_B:
        begin
          sfr_rdata_reg <= retained_scratch_b_reg;
        end
        default:
        begin
          sfr_rdata_reg <= PMSFR_RST_ZERO;
        end
      endcase
    end
  end

  // interrupt request registered so the output comes from a flop
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_event_irq_reg <= 1'b0;
    end
    else
    begin
      power_event_irq_reg <= pm_summary;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign power_event_irq = power_event_irq_reg;
  assign switchover_policy_sel = switchover_policy_sel_reg;
  assign rx_pin_function = rx_pin_function_reg;
  assign rx_wake_enable = rx_wake_enable_reg;
  assign pin_function_config = pin_function_config_reg;
endmodule : pmsfr_bank

// ---- test/pmsfr_bank_properties.sv ----
// port checker for the power management sfr bank
// assumes it is bound to pmsfr_bank; one clock domain, mclk
`timescale 1ns/1ps
module pmsfr_bank_props
  import pmsfr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic switched_supply_source_in,
  input wire logic main_supply_ok_in,
  input wire logic voltage_sag_evt,
  input wire logic supervisory_low_in,
  input wire logic pll_unlock_in,
  input wire logic rx_wake_evt,
  input wire logic [1:0] switchover_policy_sel,
  input wire logic [1:0] rx_pin_function,
  input wire logic rx_wake_enable,
  input wire logic [7:0] pin_function_config,
  input wire logic power_event_irq
);
  logic [7:0] key_reg;
  logic [7:0] en_reg;
  // shadow of key and enables, rebuilt from bus writes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_reg <= 8'h00;
      en_reg <= 8'h00;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == PMSFR_ADDR_KEY)
        key_reg <= sfr_wdata;
      if (sfr_addr == PMSFR_ADDR_EVT_EN)
        en_reg <= sfr_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_pin_open;
    sfr_wr && sfr_addr == PMSFR_ADDR_PIN_CFG && key_reg == PMSFR_KEY_UNLOCK;
  endsequence
  sequence s_pin_locked;
    sfr_wr && sfr_addr == PMSFR_ADDR_PIN_CFG && key_reg != PMSFR_KEY_UNLOCK;
  endsequence
  property p_pin_accept;
    s_pin_open |=> pin_function_config == $past(sfr_wdata);
  endproperty
  property p_pin_refuse;
    s_pin_locked |=> $stable(pin_function_config);
  endproperty
  property p_policy;
    sfr_wr && sfr_addr == PMSFR_ADDR_POLICY |=> switchover_policy_sel == $past(sfr_wdata[1:0]);
  endproperty
  property p_rxfn;
    sfr_wr && sfr_addr == PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS |=> rx_pin_function == $past(sfr_wdata[1:0]);
  endproperty
  property p_wake_dec;
    rx_wake_enable == (rx_pin_function == 2'h3);
  endproperty
  property p_sag_irq;
    voltage_sag_evt && en_reg[PMSFR_BIT_SAG] |-> ##[1:3] power_event_irq;
  endproperty
  // irq lags the enables by one cycle, so both samples must be clear
  property p_irq_masked;
    (en_reg & PMSFR_EVT_MASK) == 8'h00 && ($past(en_reg) & PMSFR_EVT_MASK) == 8'h00 |-> !power_event_irq;
  endproperty
  property p_reset_vals;
    $rose(rst_n) |-> switchover_policy_sel == PMSFR_RST_POLICY && rx_pin_function == PMSFR_RST_RXFN
      && pin_function_config == 8'h00 && !power_event_irq;
  endproperty
  a_pin_accept: assert property (p_pin_accept) else $error("pin config write lost");
  a_pin_refuse: assert property (p_pin_refuse) else $error("locked pin config changed");
  a_policy: assert property (p_policy) else $error("policy field wrong");
  a_rxfn: assert property (p_rxfn) else $error("rx function wrong");
  a_wake_dec: assert property (p_wake_dec) else $error("wake enable decode wrong");
  a_sag_irq: assert property (p_sag_irq) else $error("sag did not raise irq");
  a_irq_masked: assert property (p_irq_masked) else $error("irq with no enables");
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset values");
endmodule : pmsfr_bank_props
bind pmsfr_bank pmsfr_bank_props u_props (.*);

// ---- test/pmsfr_core_model.sv ----
// model of the processor core side of the sfr bus
// assumes mclk from the bench; bus signals move on the falling edge
`timescale 1ns/1ps
module pmsfr_core_model
  import pmsfr_pkg::*;
(
  input wire logic mclk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // one-cycle strobe; released bus shows inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : wr
  // data is registered at the read edge and held, so take it half a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask : rd
  // key opens one protected write and is closed at once against runaway code
  task automatic wr_locked(input logic [7:0] a, input logic [7:0] d);
    wr(PMSFR_ADDR_KEY, PMSFR_KEY_UNLOCK);
    wr(a, d);
    wr(PMSFR_ADDR_KEY, 8'h00);
  endtask : wr_locked
endmodule : pmsfr_core_model

// ---- test/power_mgmt_sfr_bank_tb.sv ----
// self-checking bench for the power management sfr bank
// assumes the core model drives the bus; status pins are driven here
`timescale 1ns/1ps
module power_mgmt_sfr_bank_tb;
  import pmsfr_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic src = 1'b1;
  logic mok = 1'b1;
  logic sag = 1'b0;
  logic sup = 1'b0;
  logic pll = 1'b0;
  logic wake = 1'b0;
  logic [7:0] addr, wdata, rdata, pin, d;
  logic wr, rd, wen, irq;
  logic [1:0] pol, rxf;
  logic [1:0] rxc [3] = '{2'h0, 2'h1, 2'h3};
  int n_fail = 0;
  int tests_run = 0;
  always #5 mclk = ~mclk;
  pmsfr_bank u_dut (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .switched_supply_source_in(src), .main_supply_ok_in(mok),
    .voltage_sag_evt(sag), .supervisory_low_in(sup), .pll_unlock_in(pll), .rx_wake_evt(wake),
    .switchover_policy_sel(pol), .rx_pin_function(rxf), .rx_wake_enable(wen), .pin_function_config(pin),
    .power_event_irq(irq));
  pmsfr_core_model u_core (.mclk(mclk), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
    .sfr_rdata(rdata));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    u_core.rd(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask : rc
  // status pins pass a synchroniser, so give them time to land
  task automatic settle();
    repeat (8) @(negedge mclk);
  endtask : settle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    por_n = 1'b1;
    settle();
    rc(PMSFR_ADDR_EVT_FLAGS, 8'h00);
    rc(PMSFR_ADDR_EVT_EN, 8'h00);
    rc(PMSFR_ADDR_POLICY, 8'h00);
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h60);
    rc(PMSFR_ADDR_SCRATCH_B, 8'h00);
    rc(8'h10, 8'h00);
    $display("test reset values done");
    u_core.wr(PMSFR_ADDR_PIN_CFG, 8'h80);
    chk("pin cfg", 8'h00, pin);
    u_core.wr_locked(PMSFR_ADDR_PIN_CFG, 8'h80);
    chk("pin cfg", 8'h80, pin);
    rc(PMSFR_ADDR_KEY, 8'h00);
    u_core.wr(PMSFR_ADDR_PIN_CFG, 8'h55);
    chk("pin cfg", 8'h80, pin);
    $display("test key guard done");
    for (int i = 0; i < 4; i++)
    begin
      u_core.wr(PMSFR_ADDR_POLICY, 8'(i));
      chk("policy", 8'(i), {6'h00, pol});
    end
    foreach (rxc[i])
    begin
      u_core.wr(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, {6'h00, rxc[i]});
      chk("rx fn", {6'h00, rxc[i]}, {6'h00, rxf});
      chk("wake en", {7'h00, rxc[i] == 2'h3}, {7'h00, wen});
    end
    $display("test codes done");
    u_core.wr(PMSFR_ADDR_EVT_EN, 8'hA3);
    rc(PMSFR_ADDR_EVT_EN, 8'hA3);
    @(negedge mclk) sag = 1'b1;
    @(negedge mclk) sag = 1'b0;
    settle();
    rc(PMSFR_ADDR_EVT_FLAGS, 8'h60);
    chk("irq", 8'h01, {7'h00, irq});
    u_core.wr(PMSFR_ADDR_EVT_FLAGS, 8'h00);
    rc(PMSFR_ADDR_EVT_FLAGS, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    src = 1'b0;
    settle();
    rc(PMSFR_ADDR_EVT_FLAGS, 8'h42);
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h23);
    src = 1'b1;
    settle();
    rc(PMSFR_ADDR_EVT_FLAGS, 8'hC2);
    sup = 1'b1;
    settle();
    rc(PMSFR_ADDR_EVT_FLAGS, 8'hC3);
    u_core.wr(PMSFR_ADDR_EVT_EN, 8'h00);
    rc(PMSFR_ADDR_EVT_FLAGS, 8'h83);
    chk("irq", 8'h00, {7'h00, irq});
    mok = 1'b0;
    settle();
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h43);
    mok = 1'b1;
    @(negedge mclk) wake = 1'b1;
    @(negedge mclk) wake = 1'b0;
    settle();
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'hE3);
    u_core.wr(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h03);
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h63);
    pll = 1'b1;
    settle();
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h73);
    pll = 1'b0;
    settle();
    u_core.wr(PMSFR_ADDR_ADC_START, 8'h01);
    rc(PMSFR_ADDR_PERIPHERAL_CONFIG_STATUS, 8'h63);
    $display("test events done");
    u_core.wr(PMSFR_ADDR_SCRATCH_A, 8'h5A);
    u_core.wr(PMSFR_ADDR_SCRATCH_B, 8'hA5);
    rst_n = 1'b0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    rc(PMSFR_ADDR_SCRATCH_A, 8'h5A);
    rc(PMSFR_ADDR_SCRATCH_B, 8'hA5);
    por_n = 1'b0;
    @(negedge mclk) por_n = 1'b1;
    rc(PMSFR_ADDR_SCRATCH_A, 8'h00);
    $display("test scratch done");
    report_and_stop();
  end
endmodule : power_mgmt_sfr_bank_tb
